// File: design/io_space_pkg.sv
// Package with register offsets, field positions, reset values and clock option encodings
package io_space_pkg;
  localparam logic [5:0] ADDR_COMPARATOR_CTRL_STATUS = 6'h08;
  localparam logic [5:0] ADDR_PORT_PIN_INPUT = 6'h16;
  localparam logic [5:0] ADDR_PORT_DIRECTION = 6'h17;
  localparam logic [5:0] ADDR_PORT_OUTPUT_LATCH = 6'h18;
  localparam logic [5:0] ADDR_WATCHDOG_CONTROL = 6'h21;
  localparam logic [5:0] ADDR_COUNTER_VALUE = 6'h32;
  localparam logic [5:0] ADDR_COUNTER_CLOCK_SELECT = 6'h33;
  localparam logic [5:0] ADDR_RESET_CAUSE_STATUS = 6'h34;
  localparam logic [5:0] ADDR_CORE_SLEEP_IRQ_CONTROL = 6'h35;
  localparam logic [5:0] ADDR_COUNTER_FLAG = 6'h38;
  localparam logic [5:0] ADDR_COUNTER_IRQ_MASK = 6'h39;
  localparam logic [5:0] ADDR_EXTERNAL_IRQ_FLAGS = 6'h3a;
  localparam logic [5:0] ADDR_EXTERNAL_IRQ_MASK = 6'h3b;
  localparam logic [5:0] ADDR_PROCESSOR_FLAGS = 6'h3f;
  // Highest address reachable by the bit set and clear instructions
  localparam logic [5:0] ADDR_BIT_OP_LIMIT = 6'h1f;
  // Implemented-bit masks per register
  localparam logic [7:0] MASK_COMPARATOR = 8'hdb;
  localparam logic [7:0] MASK_COMPARATOR_W1C = 8'h10;
  localparam logic [7:0] MASK_WATCHDOG = 8'h1f;
  localparam logic [7:0] MASK_CLOCK_SELECT = 8'h07;
  localparam logic [7:0] MASK_RESET_CAUSE = 8'h0f;
  localparam logic [7:0] MASK_SLEEP_CTRL = 8'h73;
  localparam logic [7:0] MASK_COUNTER_FLAG = 8'h02;
  localparam logic [7:0] MASK_EXT_IRQ = 8'h60;
  // Field positions
  localparam int BIT_PULLUP_DISABLE = 6;
  localparam int BIT_SLEEP_ENABLE = 5;
  localparam int BIT_SLEEP_MODE = 4;
  localparam int BIT_PIN_CHANGE_FLAG = 5;
  // Reset values
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // Clock option encodings
  localparam logic [2:0] CLKOPT_CRYSTAL = 3'h0;
  localparam logic [2:0] CLKOPT_LF_CRYSTAL = 3'h1;
  localparam logic [2:0] CLKOPT_RESONATOR = 3'h2;
  localparam logic [2:0] CLKOPT_EXT_RC = 3'h3;
  localparam logic [2:0] CLKOPT_EXT_CLOCK = 3'h4;
  localparam logic [2:0] CLKOPT_INT_RC = 3'h5;
  // Sleep states, Gray coded
  typedef enum logic [1:0] {
    SLEEP_RUN = 2'b00,
    SLEEP_IDLE = 2'b01,
    SLEEP_POWER_DOWN = 2'b11
  } sleep_state_e;
endpackage

// File: design/pin_sync.sv
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] first_reg;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_reg <= '0;
      sync_out <= '0;
    end else if (enable_in) begin
      first_reg <= async_in;
      sync_out <= first_reg;
    end
  end
endmodule // pin_sync
`default_nettype wire

// File: design/pin_pad_ctrl.sv
// Per-line pad control: direction, pull-up and function sharing
`timescale 1ns/1ns
`default_nettype none
module pin_pad_ctrl (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic has_eeprom_in,
  input wire logic ext_reset_en_in,
  input wire logic [2:0] clock_option_in,
  input wire logic pullup_disable_in,
  input wire logic [5:0] direction_in,
  input wire logic [4:0] latch_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_out,
  output logic [5:0] pullup_en_out,
  output logic [5:0] port_owned_out
);
  logic [5:0] owned;
  logic [5:0] drive;
  logic [5:0] level;
  logic [5:0] pull;
  logic lines_ab_taken;
  logic line_a_taken;
  logic top_out_ok;
  ////////////////////////////////////////////////////////////////////////
  assign lines_ab_taken = (clock_option_in == io_space_pkg::CLKOPT_CRYSTAL) ||
    (clock_option_in == io_space_pkg::CLKOPT_LF_CRYSTAL) ||
    (clock_option_in == io_space_pkg::CLKOPT_RESONATOR);
  assign line_a_taken = lines_ab_taken || (clock_option_in == io_space_pkg::CLKOPT_EXT_RC) ||
    (clock_option_in == io_space_pkg::CLKOPT_EXT_CLOCK);
  assign top_out_ok = has_eeprom_in && !ext_reset_en_in;
  assign owned = {!ext_reset_en_in, !lines_ab_taken, !line_a_taken, 3'b111};
  // Top line is open drain: it only ever drives low
  assign drive = owned & direction_in & {top_out_ok, 5'b11111};
  assign level = {1'b0, latch_in};
  assign pull = owned & ~direction_in & {1'b0, latch_in} & {6{!pullup_disable_in}};
  ////////////////////////////////////////////////////////////////////////
  // Asynchronous reset tri-states every pin without a clock
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out <= 6'h00;
      pin_oe_out <= 6'h00;
      pullup_en_out <= 6'h00;
      port_owned_out <= 6'h00;
    end else if (enable_in) begin
      pin_out <= level;
      pin_oe_out <= drive;
      pullup_en_out <= pull;
      port_owned_out <= owned;
    end
  end
endmodule // pin_pad_ctrl
`default_nettype wire

// File: design/io_register_space.sv
// I/O register space and six-line port of the small controller
// Operation
// - Idle sleep halts core, counter and interrupts run
// - Power-down keeps registers, stops clock until wake
// - Pin change wakes device and raises interrupt
// - Six-bit port, five lines with pull-ups
// - Top line input only or open drain
// - Reset tri-states all pins without clock
// - External reset option claims the top line
// - Crystal and resonator options claim fourth and fifth lines; RC and external clock claim the fourth
// - Reset pin low pulse resets without clock
// - Writing one clears status flags, zero keeps; reset cause flags clear on zero instead
// - Bit ops rewrite whole register, clearing flags
// - Bit ops only reach addresses 00 to 1f
`timescale 1ns/1ns
`default_nettype none
module io_register_space (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clock_enable_in,
  input wire logic has_eeprom_in,
  input wire logic ext_reset_en_in,
  input wire logic [2:0] clock_option_in,
  input wire logic [5:0] io_addr_in,
  input wire logic io_read_in,
  input wire logic io_write_in,
  input wire logic bit_set_instruction_in,
  input wire logic bit_clear_instruction_in,
  input wire logic [2:0] bit_index_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic sleep_exec_in,
  input wire logic wake_event_in,
  input wire logic counter_overflow_in,
  input wire logic comparator_event_in,
  input wire logic ext_int_event_in,
  input wire logic [5:0] port_pin_in,
  output logic [7:0] io_rdata_out,
  output logic bit_op_refused_out,
  output logic core_halt_out,
  output logic osc_stop_out,
  output logic peripherals_run_out,
  output logic pin_change_irq_out,
  output logic [5:0] port_pin_out,
  output logic [5:0] port_pin_oe_out,
  output logic [5:0] port_pullup_en_out,
  output logic [7:0] counter_value_out,
  output logic [7:0] counter_clock_select_out,
  output logic [7:0] watchdog_control_out
);
  logic [7:0] comparator_ctrl_status_reg, comparator_ctrl_status_next;
  logic [5:0] port_direction_reg, port_direction_next;
  logic [4:0] port_output_latch_reg, port_output_latch_next;
  logic [7:0] watchdog_control_reg, watchdog_control_next;
  logic [7:0] counter_value_reg, counter_value_next;
  logic [7:0] counter_clock_select_reg, counter_clock_select_next;
  logic [7:0] reset_cause_status_reg, reset_cause_status_next;
  logic [7:0] core_sleep_irq_control_reg, core_sleep_irq_control_next;
  logic [7:0] counter_flag_reg, counter_flag_next;
  logic [7:0] counter_irq_mask_reg, counter_irq_mask_next;
  logic [7:0] external_irq_flags_reg, external_irq_flags_next;
  logic [7:0] external_irq_mask_reg, external_irq_mask_next;
  logic [7:0] processor_flags_reg, processor_flags_next;
  logic [5:0] pin_last_reg;
  logic ext_reset_seen_reg;
  io_space_pkg::sleep_state_e sleep_reg, sleep_next;
  logic [5:0] pins_sync;
  logic [5:0] port_owned;
  logic [7:0] rdata_next;
  logic [7:0] port_pin_value;
  logic bit_op;
  logic bit_op_ok;
  logic any_write;
  logic [7:0] bit_mask;
  logic [7:0] rmw_value;
  logic [7:0] wvalue;
  logic pin_change;
  logic clk_live;
  logic irq_pending;

  ////////////////////////////////////////////////////////////////////////
  // Helper functions
  function automatic logic hit(input logic [5:0] addr, input logic [5:0] target);
    return addr == target;
  endfunction

  // Write-one-to-clear update: hardware set wins over a clear in the same cycle
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                     input logic [7:0] clr, input logic [7:0] mask);
    return ((cur & ~clr) | set) & mask;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Synchronised pins and pad control
  pin_sync #(.WIDTH(6)) u_pin_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .enable_in(clock_enable_in),
    .async_in(port_pin_in),
    .sync_out(pins_sync)
  );

  pin_pad_ctrl u_pad (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .enable_in(clk_live),
    .has_eeprom_in(has_eeprom_in),
    .ext_reset_en_in(ext_reset_en_in),
    .clock_option_in(clock_option_in),
    .pullup_disable_in(core_sleep_irq_control_reg[io_space_pkg::BIT_PULLUP_DISABLE]),
    .direction_in(port_direction_reg),
    .latch_in(port_output_latch_reg),
    .pin_out(port_pin_out),
    .pin_oe_out(port_pin_oe_out),
    .pullup_en_out(port_pullup_en_out),
    .port_owned_out(port_owned)
  );

  ////////////////////////////////////////////////////////////////////////
  // Access decode
  // Power-down freezes state; only a wake event, a pin change or reset restarts the clock
  assign clk_live = clock_enable_in &&
    ((sleep_reg != io_space_pkg::SLEEP_POWER_DOWN) || wake_event_in || pin_change);
  assign bit_op = bit_set_instruction_in || bit_clear_instruction_in;
  assign bit_op_ok = bit_op && (io_addr_in <= io_space_pkg::ADDR_BIT_OP_LIMIT);
  assign any_write = io_write_in || bit_op_ok;
  assign bit_mask = 8'h01 << bit_index_in;
  assign port_pin_value = {2'b00, pins_sync & port_owned};
  assign rmw_value = bit_set_instruction_in ? (rdata_next | bit_mask) : (rdata_next & ~bit_mask);
  assign wvalue = bit_op_ok ? rmw_value : io_wdata_in;
  assign pin_change = |((pins_sync ^ pin_last_reg) & port_owned);
  assign irq_pending = processor_flags_reg[7] &&
    (|(external_irq_flags_reg & external_irq_mask_reg) || |(counter_flag_reg & counter_irq_mask_reg));

  always_comb begin
    unique case (io_addr_in)
      io_space_pkg::ADDR_COMPARATOR_CTRL_STATUS: rdata_next = comparator_ctrl_status_reg;
      io_space_pkg::ADDR_PORT_PIN_INPUT: rdata_next = port_pin_value;
      io_space_pkg::ADDR_PORT_DIRECTION: rdata_next = {2'b00, port_direction_reg};
      io_space_pkg::ADDR_PORT_OUTPUT_LATCH: rdata_next = {3'b000, port_output_latch_reg};
      io_space_pkg::ADDR_WATCHDOG_CONTROL: rdata_next = watchdog_control_reg;
      io_space_pkg::ADDR_COUNTER_VALUE: rdata_next = counter_value_reg;
      io_space_pkg::ADDR_COUNTER_CLOCK_SELECT: rdata_next = counter_clock_select_reg;
      io_space_pkg::ADDR_RESET_CAUSE_STATUS: rdata_next = reset_cause_status_reg;
      io_space_pkg::ADDR_CORE_SLEEP_IRQ_CONTROL: rdata_next = core_sleep_irq_control_reg;
      io_space_pkg::ADDR_COUNTER_FLAG: rdata_next = counter_flag_reg;
      io_space_pkg::ADDR_COUNTER_IRQ_MASK: rdata_next = counter_irq_mask_reg;
      io_space_pkg::ADDR_EXTERNAL_IRQ_FLAGS: rdata_next = external_irq_flags_reg;
      io_space_pkg::ADDR_EXTERNAL_IRQ_MASK: rdata_next = external_irq_mask_reg;
      io_space_pkg::ADDR_PROCESSOR_FLAGS: rdata_next = processor_flags_reg;
      default: rdata_next = io_space_pkg::RESET_VALUE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Register next values; writes mask reserved bits away
  assign port_direction_next = (any_write && hit(io_addr_in, io_space_pkg::ADDR_PORT_DIRECTION)) ?
    wvalue[5:0] : port_direction_reg;
  assign port_output_latch_next = (any_write && hit(io_addr_in, io_space_pkg::ADDR_PORT_OUTPUT_LATCH)) ?
    wvalue[4:0] : port_output_latch_reg;
  assign watchdog_control_next = (io_write_in && hit(io_addr_in, io_space_pkg::ADDR_WATCHDOG_CONTROL)) ?
    (wvalue & io_space_pkg::MASK_WATCHDOG) : watchdog_control_reg;
  assign counter_value_next = (io_write_in && hit(io_addr_in, io_space_pkg::ADDR_COUNTER_VALUE)) ?
    wvalue : counter_value_reg;
  assign counter_clock_select_next =
    (io_write_in && hit(io_addr_in, io_space_pkg::ADDR_COUNTER_CLOCK_SELECT)) ?
    (wvalue & io_space_pkg::MASK_CLOCK_SELECT) : counter_clock_select_reg;
  assign core_sleep_irq_control_next =
    (io_write_in && hit(io_addr_in, io_space_pkg::ADDR_CORE_SLEEP_IRQ_CONTROL)) ?
    (wvalue & io_space_pkg::MASK_SLEEP_CTRL) : core_sleep_irq_control_reg;
  assign counter_irq_mask_next = (io_write_in && hit(io_addr_in, io_space_pkg::ADDR_COUNTER_IRQ_MASK)) ?
    (wvalue & io_space_pkg::MASK_COUNTER_FLAG) : counter_irq_mask_reg;
  assign external_irq_mask_next = (io_write_in && hit(io_addr_in, io_space_pkg::ADDR_EXTERNAL_IRQ_MASK)) ?
    (wvalue & io_space_pkg::MASK_EXT_IRQ) : external_irq_mask_reg;
  assign processor_flags_next = (io_write_in && hit(io_addr_in, io_space_pkg::ADDR_PROCESSOR_FLAGS)) ?
    wvalue : processor_flags_reg;
  // Comparator: control bits plain, event flag write-one-to-clear
  assign comparator_ctrl_status_next =
    (any_write && hit(io_addr_in, io_space_pkg::ADDR_COMPARATOR_CTRL_STATUS)) ?
    (((wvalue & ~io_space_pkg::MASK_COMPARATOR_W1C) & io_space_pkg::MASK_COMPARATOR) |
     w1c(comparator_ctrl_status_reg, {3'b000, comparator_event_in, 4'h0}, wvalue,
         io_space_pkg::MASK_COMPARATOR_W1C)) :
    (comparator_ctrl_status_reg | {3'b000, comparator_event_in, 4'h0});
  assign counter_flag_next = w1c(counter_flag_reg, {6'h00, counter_overflow_in, 1'b0},
    (io_write_in && hit(io_addr_in, io_space_pkg::ADDR_COUNTER_FLAG)) ? wvalue : 8'h00,
    io_space_pkg::MASK_COUNTER_FLAG);
  assign external_irq_flags_next = w1c(external_irq_flags_reg,
    {1'b0, ext_int_event_in, pin_change, 5'h00},
    (io_write_in && hit(io_addr_in, io_space_pkg::ADDR_EXTERNAL_IRQ_FLAGS)) ? wvalue : 8'h00,
    io_space_pkg::MASK_EXT_IRQ);
  assign reset_cause_status_next = w1c(reset_cause_status_reg,
    {6'h00, ext_reset_seen_reg, 1'b0},
    (io_write_in && hit(io_addr_in, io_space_pkg::ADDR_RESET_CAUSE_STATUS)) ? ~wvalue : 8'h00,
    io_space_pkg::MASK_RESET_CAUSE);

  ////////////////////////////////////////////////////////////////////////
  // Sleep control
  always_comb begin
    sleep_next = sleep_reg;
    case (sleep_reg)
      io_space_pkg::SLEEP_RUN: begin
        if (sleep_exec_in && core_sleep_irq_control_reg[io_space_pkg::BIT_SLEEP_ENABLE]) begin
          sleep_next = core_sleep_irq_control_reg[io_space_pkg::BIT_SLEEP_MODE] ?
            io_space_pkg::SLEEP_POWER_DOWN : io_space_pkg::SLEEP_IDLE;
        end
      end
      io_space_pkg::SLEEP_IDLE: begin
        if (irq_pending || wake_event_in || pin_change) begin
          sleep_next = io_space_pkg::SLEEP_RUN;
        end
      end
      io_space_pkg::SLEEP_POWER_DOWN: begin
        if (wake_event_in || pin_change) begin
          sleep_next = io_space_pkg::SLEEP_RUN;
        end
      end
      default: sleep_next = io_space_pkg::SLEEP_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers; the pin reset is asynchronous so no clock is needed
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      comparator_ctrl_status_reg <= io_space_pkg::RESET_VALUE;
      port_direction_reg <= 6'h00;
      port_output_latch_reg <= 5'h00;
      watchdog_control_reg <= io_space_pkg::RESET_VALUE;
      counter_value_reg <= io_space_pkg::RESET_VALUE;
      counter_clock_select_reg <= io_space_pkg::RESET_VALUE;
      reset_cause_status_reg <= io_space_pkg::RESET_VALUE;
      core_sleep_irq_control_reg <= io_space_pkg::RESET_VALUE;
      counter_flag_reg <= io_space_pkg::RESET_VALUE;
      counter_irq_mask_reg <= io_space_pkg::RESET_VALUE;
      external_irq_flags_reg <= io_space_pkg::RESET_VALUE;
      external_irq_mask_reg <= io_space_pkg::RESET_VALUE;
      processor_flags_reg <= io_space_pkg::RESET_VALUE;
      sleep_reg <= io_space_pkg::SLEEP_RUN;
      ext_reset_seen_reg <= 1'b1;
      pin_last_reg <= 6'h00;
    end else if (clk_live) begin
      comparator_ctrl_status_reg <= comparator_ctrl_status_next;
      port_direction_reg <= port_direction_next;
      port_output_latch_reg <= port_output_latch_next;
      watchdog_control_reg <= watchdog_control_next;
      counter_value_reg <= counter_value_next;
      counter_clock_select_reg <= counter_clock_select_next;
      reset_cause_status_reg <= reset_cause_status_next;
      core_sleep_irq_control_reg <= core_sleep_irq_control_next;
      counter_flag_reg <= counter_flag_next;
      counter_irq_mask_reg <= counter_irq_mask_next;
      external_irq_flags_reg <= external_irq_flags_next;
      external_irq_mask_reg <= external_irq_mask_next;
      processor_flags_reg <= processor_flags_next;
      sleep_reg <= sleep_next;
      ext_reset_seen_reg <= 1'b0;
      pin_last_reg <= pins_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      io_rdata_out <= 8'h00;
      bit_op_refused_out <= 1'b0;
      core_halt_out <= 1'b0;
      osc_stop_out <= 1'b0;
      peripherals_run_out <= 1'b1;
      pin_change_irq_out <= 1'b0;
      counter_value_out <= 8'h00;
      counter_clock_select_out <= 8'h00;
      watchdog_control_out <= 8'h00;
    end else if (clk_live) begin
      io_rdata_out <= io_read_in ? rdata_next : 8'h00;
      bit_op_refused_out <= bit_op && !bit_op_ok;
      core_halt_out <= sleep_next != io_space_pkg::SLEEP_RUN;
      osc_stop_out <= sleep_next == io_space_pkg::SLEEP_POWER_DOWN;
      peripherals_run_out <= sleep_next != io_space_pkg::SLEEP_POWER_DOWN;
      pin_change_irq_out <= external_irq_flags_next[io_space_pkg::BIT_PIN_CHANGE_FLAG] &&
        external_irq_mask_next[io_space_pkg::BIT_PIN_CHANGE_FLAG];
      counter_value_out <= counter_value_next;
      counter_clock_select_out <= counter_clock_select_next;
      watchdog_control_out <= watchdog_control_next;
    end
  end
endmodule // io_register_space
`default_nettype wire

// File: testbench/io_register_space_monitor.sv
// Concurrent checks on the port and register space outputs
`timescale 1ns/1ns
`default_nettype none
module io_register_space_monitor (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clock_enable_in,
  input wire logic has_eeprom_in,
  input wire logic ext_reset_en_in,
  input wire logic [2:0] clock_option_in,
  input wire logic [5:0] io_addr_in,
  input wire logic io_read_in,
  input wire logic bit_set_instruction_in,
  input wire logic bit_clear_instruction_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic bit_op_refused_out,
  input wire logic core_halt_out,
  input wire logic osc_stop_out,
  input wire logic peripherals_run_out,
  input wire logic pin_change_irq_out,
  input wire logic [5:0] port_pin_out,
  input wire logic [5:0] port_pin_oe_out,
  input wire logic [5:0] port_pullup_en_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Straps may pass a flop before the pads, so pad checks wait for two stable cycles
  wire logic live = clock_enable_in && !osc_stop_out;
  wire logic bop = bit_set_instruction_in || bit_clear_instruction_in;
  wire logic high_addr = io_addr_in > io_space_pkg::ADDR_BIT_OP_LIMIT;
  property p_top_line;
    $stable({has_eeprom_in, ext_reset_en_in}) [*2] ##0 port_pin_oe_out[5]
      |-> has_eeprom_in && !ext_reset_en_in && !port_pin_out[5];
  endproperty
  a_top_line: assert property (p_top_line) else $error("top line driven wrongly");
  property p_crystal_lines;
    $stable(clock_option_in) [*2] ##0 clock_option_in <= 3'h2
      |-> port_pin_oe_out[4:3] == 2'h0 && port_pullup_en_out[4:3] == 2'h0;
  endproperty
  a_crystal_lines: assert property (p_crystal_lines) else $error("clock lines used");
  property p_rc_line;
    $stable(clock_option_in) [*2] ##0 clock_option_in inside {3'h3, 3'h4} |-> !port_pin_oe_out[3];
  endproperty
  a_rc_line: assert property (p_rc_line) else $error("clock input line driven");
  property p_reserved_read;
    io_read_in && live && io_addr_in == 6'h00 |=> io_rdata_out == 8'h00;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved read not 0");
  property p_refuse;
    bop && live && high_addr |=> bit_op_refused_out;
  endproperty
  a_refuse: assert property (p_refuse) else $error("high bit op not refused");
  property p_refuse_cause;
    bit_op_refused_out |-> $past(bop && high_addr);
  endproperty
  a_refuse_cause: assert property (p_refuse_cause) else $error("refusal without cause");
  property p_power_down;
    osc_stop_out |-> core_halt_out && !peripherals_run_out;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down outputs wrong");
  property p_idle;
    core_halt_out && !osc_stop_out |-> peripherals_run_out;
  endproperty
  a_idle: assert property (p_idle) else $error("idle stopped peripherals");
  property p_pullup;
    (port_pullup_en_out & port_pin_oe_out) == 6'h00;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on driven line");
  c_refused: cover property (bit_op_refused_out);
  c_power_down: cover property ($rose(osc_stop_out));
  c_pin_irq: cover property (pin_change_irq_out);
endmodule // io_register_space_monitor
bind io_register_space io_register_space_monitor io_register_space_monitor_i (.*);
`default_nettype wire

// File: testbench/pin_board_model.sv
// Board circuitry on the six port lines
`timescale 1ns/1ns
`default_nettype none
module pin_board_model (
  input wire logic [5:0] pin_out_in,
  input wire logic [5:0] oe_in,
  input wire logic [5:0] pullup_in,
  input wire logic [5:0] board_val_in,
  input wire logic [5:0] board_en_in,
  output logic [5:0] level_out
);
  // Floating lines without pull-up show the inverse of the board value, never a stale level
  assign level_out = (oe_in & pin_out_in) | (~oe_in & board_en_in & board_val_in)
    | (~oe_in & ~board_en_in & (pullup_in | ~board_val_in));
endmodule // pin_board_model
`default_nettype wire

// File: testbench/io_register_space_tb.sv
// Self-checking bench for the I/O register space
`timescale 1ns/1ns
`default_nettype none
module io_register_space_tb;
  logic clock_in = 1'b0, rst_n_in = 1'b0, clock_enable_in = 1'b1, has_eeprom_in = 1'b1;
  logic ext_reset_en_in = 1'b0, io_read_in = 1'b0, io_write_in = 1'b0, sleep_exec_in = 1'b0;
  logic bit_set_instruction_in = 1'b0, bit_clear_instruction_in = 1'b0, wake_event_in = 1'b0;
  logic counter_overflow_in = 1'b0, comparator_event_in = 1'b0, ext_int_event_in = 1'b0;
  logic [2:0] clock_option_in = 3'h5, bit_index_in = 3'h0;
  logic [5:0] io_addr_in = 6'h00, board_val = 6'h00, board_en = 6'h00, port_pin_in;
  logic [7:0] io_wdata_in = 8'h00, d, io_rdata_out, counter_value_out, counter_clock_select_out;
  logic [7:0] watchdog_control_out;
  logic bit_op_refused_out, core_halt_out, osc_stop_out, peripherals_run_out, pin_change_irq_out;
  logic [5:0] port_pin_out, port_pin_oe_out, port_pullup_en_out;
  int err_count = 0, n_tests = 0;
  io_register_space io_register_space_i (.*);
  pin_board_model pin_board_model_i (.pin_out_in(port_pin_out), .oe_in(port_pin_oe_out),
    .pullup_in(port_pullup_en_out), .board_val_in(board_val), .board_en_in(board_en),
    .level_out(port_pin_in));
  function automatic logic [1:0] clk_oe(input logic [2:0] opt);
    return (opt <= 3'h2) ? 2'h0 : (opt <= 3'h4) ? 2'h2 : 2'h3;
  endfunction
  task automatic stop_test();
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock_in);
    s = 1'b1;
    @(negedge clock_in);
    s = 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    io_addr_in = a;
    io_wdata_in = v;
    pulse(io_write_in);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    io_addr_in = a;
    pulse(io_read_in);
    chk("read", io_rdata_out, exp);
  endtask
  task automatic bop(input logic [1:0] kind, input logic [5:0] a, input logic [2:0] idx);
    @(negedge clock_in);
    io_addr_in = a;
    bit_index_in = idx;
    {bit_set_instruction_in, bit_clear_instruction_in} = kind;
    @(negedge clock_in);
    {bit_set_instruction_in, bit_clear_instruction_in} = 2'h0;
  endtask
  // Bounded wait; running out ends the run
  task automatic wait_val(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 20) begin
      @(negedge clock_in);
      n++;
    end
    chk("wait", {7'h0, s}, {7'h0, v});
    if (n == 20) stop_test();
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 clock_in = ~clock_in;
  end
  initial begin
    void'($urandom(64));
    repeat (10) @(negedge clock_in);
    chk("oe_rst", {2'h0, port_pin_oe_out}, 8'h00);
    rst_n_in = 1'b1;
    rchk(6'h17, 8'h00);
    repeat (4) begin
      d = $urandom;
      wr(6'h17, d);
      rchk(6'h17, d & 8'h3f);
      wr(6'h32, d);
      wr(6'h00, ~d);
      rchk(6'h00, 8'h00);
      chk("cnt", counter_value_out, d);
    end
    d = $urandom;
    board_val = 6'($urandom);
    board_en = 6'h20;
    wr(6'h17, 8'h1f);
    wr(6'h18, d);
    repeat (6) @(negedge clock_in);
    chk("oe", {2'h0, port_pin_oe_out}, 8'h1f);
    chk("out", {3'h0, port_pin_out[4:0]}, {3'h0, d[4:0]});
    rchk(6'h16, {2'h0, board_val[5], d[4:0]});
    wr(6'h17, 8'h00);
    wr(6'h18, 8'h1f);
    repeat (6) @(negedge clock_in);
    chk("pull", {2'h0, port_pullup_en_out}, 8'h1f);
    rchk(6'h16, {2'h0, board_val[5], 5'h1f});
    wr(6'h35, 8'h40);
    repeat (3) @(negedge clock_in);
    chk("pull_off", {2'h0, port_pullup_en_out}, 8'h00);
    wr(6'h17, 8'h3f);
    for (int i = 0; i < 8; i++) begin
      clock_option_in = 3'(i);
      {ext_reset_en_in, has_eeprom_in} = 2'(i);
      repeat (4) @(negedge clock_in);
      chk("clk_lines", {6'h0, port_pin_oe_out[4:3]}, {6'h0, clk_oe(3'(i))});
    end
    clock_option_in = 3'h5;
    {ext_reset_en_in, has_eeprom_in} = 2'h1;
    pulse(counter_overflow_in);
    rchk(6'h38, 8'h02);
    wr(6'h38, 8'h00);
    rchk(6'h38, 8'h02);
    wr(6'h38, 8'h02);
    rchk(6'h38, 8'h00);
    pulse(comparator_event_in);
    bop(2'h2, 6'h08, 3'h0);
    rchk(6'h08, 8'h01);
    wr(6'h32, 8'h5a);
    bop(2'h2, 6'h32, 3'h0);
    chk("cnt_bop", counter_value_out, 8'h5a);
    bop(2'h1, 6'h08, 3'h0);
    rchk(6'h08, 8'h00);
    clock_enable_in = 1'b0;
    wr(6'h32, 8'ha5);
    clock_enable_in = 1'b1;
    chk("cnt_frozen", counter_value_out, 8'h5a);
    wr(6'h35, 8'h30);
    pulse(sleep_exec_in);
    wait_val(osc_stop_out, 1'b1);
    wr(6'h32, 8'h00);
    chk("cnt_pd", counter_value_out, 8'h5a);
    pulse(wake_event_in);
    wait_val(osc_stop_out, 1'b0);
    wr(6'h35, 8'h20);
    pulse(sleep_exec_in);
    wait_val(core_halt_out, 1'b1);
    chk("run", {7'h0, peripherals_run_out}, 8'h01);
    pulse(counter_overflow_in);
    pulse(wake_event_in);
    wait_val(core_halt_out, 1'b0);
    rchk(6'h38, 8'h02);
    wr(6'h17, 8'h00);
    board_en = 6'h3f;
    board_val = 6'h00;
    wr(6'h3b, 8'h20);
    wr(6'h3a, 8'h20);
    board_val = 6'h01;
    wait_val(pin_change_irq_out, 1'b1);
    wr(6'h3a, 8'h20);
    wait_val(pin_change_irq_out, 1'b0);
    wr(6'h35, 8'h30);
    pulse(sleep_exec_in);
    wait_val(osc_stop_out, 1'b1);
    board_val = 6'h03;
    wait_val(osc_stop_out, 1'b0);
    wr(6'h17, 8'h1f);
    repeat (3) @(negedge clock_in);
    #5 rst_n_in = 1'b0;
    #1 chk("oe_async", {2'h0, port_pin_oe_out}, 8'h00);
    @(negedge clock_in);
    rst_n_in = 1'b1;
    rchk(6'h17, 8'h00);
    stop_test();
  end
endmodule // io_register_space_tb
`default_nettype wire
